// ==== logic/ifr_pkg.sv ====
// package: register map, field positions, reset values and carrier types of the flag block
package ifr_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_EXT_CTRL3 = 8'h00;
   localparam logic [7:0] OFS_FLAGS1    = 8'h04;
   localparam logic [7:0] OFS_FLAGS2    = 8'h08;
   localparam logic [7:0] OFS_FLAGS3    = 8'h0c;
   localparam logic [7:0] OFS_CONFIG    = 8'h10;

   // external control register fields
   localparam int BIT_EXT2_PRIO = 7;
   localparam int BIT_EXT1_PRIO = 6;
   localparam int BIT_EXT3_EN   = 5;
   localparam int BIT_EXT2_EN   = 4;
   localparam int BIT_EXT1_EN   = 3;
   localparam int BIT_EXT3_FLAG = 2;
   localparam int BIT_EXT2_FLAG = 1;
   localparam int BIT_EXT1_FLAG = 0;

   // peripheral flag register one fields
   localparam int BIT_PARPORT   = 7;
   localparam int BIT_CONV_DONE = 6;
   localparam int BIT_SER1_RX   = 5;
   localparam int BIT_SER1_TX   = 4;
   localparam int BIT_SYNC_DONE = 3;
   localparam int BIT_CAPCOMP1  = 2;
   localparam int BIT_TMR2_PM   = 1;
   localparam int BIT_TMR1_OVF  = 0;

   // peripheral flag register two fields
   localparam int BIT_OSC_FAIL  = 7;
   localparam int BIT_CMP_CHG   = 6;
   localparam int BIT_BUS_COLL  = 3;
   localparam int BIT_VOLT_DET  = 2;
   localparam int BIT_TMR3_OVF  = 1;
   localparam int BIT_CAPCOMP2  = 0;

   // peripheral flag register three fields
   localparam int BIT_SER2_RX   = 5;
   localparam int BIT_SER2_TX   = 4;
   localparam int BIT_CAPCOMP3  = 0;

   // configuration register fields
   localparam int BIT_PRIO_EN   = 0;
   localparam int BIT_EDGE1     = 1;
   localparam int BIT_EDGE2     = 2;
   localparam int BIT_EDGE3     = 3;
   localparam int BIT_EXT3_PRIO = 4;

   // reset values
   localparam logic [7:0] RST_EXT_CTRL3 = 8'hc0;
   localparam logic [7:0] RST_FLAGS     = 8'h00;
   localparam logic [7:0] RST_CONFIG    = 8'h1e;

   // software-writable and implemented bit masks
   localparam logic [7:0] WMASK_EXT_CTRL3 = 8'hff;
   localparam logic [7:0] WMASK_FLAGS1    = 8'hcf;
   localparam logic [7:0] WMASK_FLAGS2    = 8'hcf;
   localparam logic [7:0] WMASK_FLAGS3    = 8'h01;
   localparam logic [7:0] WMASK_CONFIG    = 8'h1f;
   localparam logic [7:0] IMPL_FLAGS2     = 8'hcf;
   localparam logic [7:0] IMPL_FLAGS3     = 8'h31;

   // capture/compare unit operating mode
   typedef enum logic [1:0] {
      CCP_CAPTURE = 2'b00,
      CCP_COMPARE = 2'b01,
      CCP_PWM     = 2'b11
   } ifr_ccp_mode_t;

   // one-cycle event pulses from the peripherals
   typedef struct packed {
      logic parallel_port_access;
      logic conversion_done;
      logic sync_serial_done;
      logic capcomp1_capture;
      logic capcomp1_match;
      logic timer2_period_match;
      logic timer1_overflow;
      logic oscillator_fail;
      logic comparator_change;
      logic bus_collision;
      logic voltage_detect;
      logic timer3_overflow;
      logic capcomp2_capture;
      logic capcomp2_match;
      logic capcomp3_capture;
      logic capcomp3_match;
   } ifr_events_t;

   // buffer state levels from the two serial ports
   typedef struct packed {
      logic serial1_rx_full;
      logic serial1_tx_empty;
      logic serial2_rx_full;
      logic serial2_tx_empty;
   } ifr_status_t;

   // apb slave phase
   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_RESP = 2'b01
   } ifr_apb_state_t;

endpackage

// ==== logic/ifr_top.sv ====
// module: interrupt flag registers with external line control behind an apb slave
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ifr_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_resetn,
   input  wire logic                  i_clk_en,
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [ADDR_W-1:0]     i_paddr,
   input  wire logic [31:0]           i_pwdata,
   input  wire logic [3:0]            i_pstrb,
   output logic      [31:0]           o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr,
   input  wire logic [2:0]            i_ext_line,
   input  wire ifr_pkg::ifr_events_t  i_events,
   input  wire ifr_pkg::ifr_status_t  i_status,
   input  wire ifr_pkg::ifr_ccp_mode_t i_capcomp1_mode,
   input  wire ifr_pkg::ifr_ccp_mode_t i_capcomp2_mode,
   input  wire ifr_pkg::ifr_ccp_mode_t i_capcomp3_mode,
   output logic      [7:0]            o_ext_ctrl3,
   output logic      [7:0]            o_flags1,
   output logic      [7:0]            o_flags2,
   output logic      [7:0]            o_flags3,
   output logic                       o_ext_irq_high,
   output logic                       o_ext_irq_low
);

   // refuse address buses too narrow for the map
   if (ADDR_W < 5) begin : g_addr_check
      $error("ifr_top: ADDR_W must be at least 5");
   end

   // flag update: event wins over the written value
   function automatic logic [7:0] flag_upd(input logic [7:0] cur,
                                           input logic [7:0] ev,
                                           input logic       wr,
                                           input logic [7:0] wdata,
                                           input logic [7:0] wmask);
      logic [7:0] held;
      held = wr ? ((wdata & wmask) | (cur & ~wmask)) : cur;
      return ev | held;
   endfunction

   // capture/compare flag source chosen by unit mode
   function automatic logic capcomp_event(input ifr_pkg::ifr_ccp_mode_t mode,
                                          input logic                   cap,
                                          input logic                   match);
      logic ev;
      ev = 1'b0;
      case (mode)
         ifr_pkg::CCP_CAPTURE: ev = cap;
         ifr_pkg::CCP_COMPARE: ev = match;
         default:              ev = 1'b0;
      endcase
      return ev;
   endfunction

   // register address match on the whole address bus, offset zero-extended
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        ofs);
      return addr == ADDR_W'(ofs);
   endfunction

   // flip-flop state
   ifr_pkg::ifr_apb_state_t apb_state_r;
   logic [7:0]              ext_ctrl3_r;
   logic [7:0]              flags1_r;
   logic [7:0]              flags2_r;
   logic [7:0]              flags3_r;
   logic [7:0]              config_r;
   logic [2:0]              ext_sync1_r;
   logic [2:0]              ext_sync2_r;
   logic [2:0]              ext_prev_r;
   logic [2:0]              ext_arm_r;
   logic [31:0]             prdata_r;
   logic                    pslverr_r;
   logic                    pready_r;
   logic                    irq_high_r;
   logic                    irq_low_r;

   // combinational wiring
   logic                    wr_commit;
   logic                    wr_lane0;
   logic                    sel_ext;
   logic                    sel_f1;
   logic                    sel_f2;
   logic                    sel_f3;
   logic                    sel_cfg;
   logic                    sel_any;
   logic [2:0]              ext_edge_sel;
   logic [2:0]              ext_event;
   logic [7:0]              ev_ext;
   logic [7:0]              ev_f1;
   logic [7:0]              ev_f2;
   logic [7:0]              ev_f3;
   logic [7:0]              ext_ctrl3_nxt;
   logic [7:0]              flags1_nxt;
   logic [7:0]              flags2_nxt;
   logic [7:0]              flags3_nxt;
   logic [7:0]              config_nxt;
   logic [7:0]              rd_byte;
   logic [2:0]              ext_req;
   logic [2:0]              ext_prio;
   logic                    prio_en;

   // address decode
   assign sel_ext = addr_hit(i_paddr, ifr_pkg::OFS_EXT_CTRL3);
   assign sel_f1  = addr_hit(i_paddr, ifr_pkg::OFS_FLAGS1);
   assign sel_f2  = addr_hit(i_paddr, ifr_pkg::OFS_FLAGS2);
   assign sel_f3  = addr_hit(i_paddr, ifr_pkg::OFS_FLAGS3);
   assign sel_cfg = addr_hit(i_paddr, ifr_pkg::OFS_CONFIG);
   assign sel_any = sel_ext | sel_f1 | sel_f2 | sel_f3 | sel_cfg;

   // a write lands at the edge where the master sees pready
   assign wr_commit = i_psel & i_penable & i_pwrite & pready_r;
   assign wr_lane0  = wr_commit & i_pstrb[0];

   // apb phase tracking: one wait cycle, then answer
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         apb_state_r <= ifr_pkg::APB_IDLE;
         pready_r    <= 1'b0;
      end else if (i_clk_en) begin
         case (apb_state_r)
            ifr_pkg::APB_IDLE: begin
               if (i_psel & i_penable) begin
                  apb_state_r <= ifr_pkg::APB_RESP;
                  pready_r    <= 1'b1;
               end
            end
            ifr_pkg::APB_RESP: begin
               apb_state_r <= ifr_pkg::APB_IDLE;
               pready_r    <= 1'b0;
            end
            default: begin
               apb_state_r <= ifr_pkg::APB_IDLE;
               pready_r    <= 1'b0;
            end
         endcase
      end
   end

   // read mux, unimplemented bits forced low
   always_comb begin
      rd_byte = 8'h00;
      if (sel_ext) begin
         rd_byte = ext_ctrl3_r;
      end else if (sel_f1) begin
         rd_byte = flags1_r;
      end else if (sel_f2) begin
         rd_byte = flags2_r & ifr_pkg::IMPL_FLAGS2;
      end else if (sel_f3) begin
         rd_byte = flags3_r & ifr_pkg::IMPL_FLAGS3;
      end else if (sel_cfg) begin
         rd_byte = config_r;
      end
   end

   // read data and error answer captured with pready
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (i_clk_en) begin
         if ((apb_state_r == ifr_pkg::APB_IDLE) && i_psel && i_penable) begin
            prdata_r  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_r <= ~sel_any;
         end else begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
         end
      end
   end

   // external line pins: two-stage synchroniser then edge history
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ext_sync1_r <= 3'h0;
         ext_sync2_r <= 3'h0;
         ext_prev_r  <= 3'h0;
      end else if (i_clk_en) begin
         ext_sync1_r <= i_ext_line;
         ext_sync2_r <= ext_sync1_r;
         ext_prev_r  <= ext_sync2_r;
      end
   end

   // edges count only once the history holds real pin samples
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ext_arm_r <= 3'h0;
      end else if (i_clk_en) begin
         ext_arm_r <= {ext_arm_r[1:0], 1'b1};
      end
   end

   // edge select per line: one rising, zero falling
   assign ext_edge_sel = {config_r[ifr_pkg::BIT_EDGE3],
                          config_r[ifr_pkg::BIT_EDGE2],
                          config_r[ifr_pkg::BIT_EDGE1]};
   assign ext_event = {3{ext_arm_r[2]}} &
                      ((ext_edge_sel & ext_sync2_r & ~ext_prev_r) |
                       (~ext_edge_sel & ~ext_sync2_r & ext_prev_r));

   // external flags latch whatever the enables say
   always_comb begin
      ev_ext = 8'h00;
      ev_ext[ifr_pkg::BIT_EXT3_FLAG] = ext_event[2];
      ev_ext[ifr_pkg::BIT_EXT2_FLAG] = ext_event[1];
      ev_ext[ifr_pkg::BIT_EXT1_FLAG] = ext_event[0];
   end

   // peripheral flag register one set events
   always_comb begin
      ev_f1 = 8'h00;
      ev_f1[ifr_pkg::BIT_PARPORT]   = i_events.parallel_port_access;
      ev_f1[ifr_pkg::BIT_CONV_DONE] = i_events.conversion_done;
      ev_f1[ifr_pkg::BIT_SYNC_DONE] = i_events.sync_serial_done;
      ev_f1[ifr_pkg::BIT_CAPCOMP1]  = capcomp_event(i_capcomp1_mode,
                                                    i_events.capcomp1_capture,
                                                    i_events.capcomp1_match);
      ev_f1[ifr_pkg::BIT_TMR2_PM]   = i_events.timer2_period_match;
      ev_f1[ifr_pkg::BIT_TMR1_OVF]  = i_events.timer1_overflow;
   end

   // peripheral flag register two set events
   always_comb begin
      ev_f2 = 8'h00;
      ev_f2[ifr_pkg::BIT_OSC_FAIL] = i_events.oscillator_fail;
      ev_f2[ifr_pkg::BIT_CMP_CHG]  = i_events.comparator_change;
      ev_f2[ifr_pkg::BIT_BUS_COLL] = i_events.bus_collision;
      ev_f2[ifr_pkg::BIT_VOLT_DET] = i_events.voltage_detect;
      ev_f2[ifr_pkg::BIT_TMR3_OVF] = i_events.timer3_overflow;
      ev_f2[ifr_pkg::BIT_CAPCOMP2] = capcomp_event(i_capcomp2_mode,
                                                   i_events.capcomp2_capture,
                                                   i_events.capcomp2_match);
   end

   // peripheral flag register three set events
   always_comb begin
      ev_f3 = 8'h00;
      ev_f3[ifr_pkg::BIT_CAPCOMP3] = capcomp_event(i_capcomp3_mode,
                                                   i_events.capcomp3_capture,
                                                   i_events.capcomp3_match);
   end

   // next register values; set beats a clearing write
   always_comb begin
      ext_ctrl3_nxt = flag_upd(ext_ctrl3_r, ev_ext, wr_lane0 & sel_ext,
                               i_pwdata[7:0], ifr_pkg::WMASK_EXT_CTRL3);
      flags1_nxt = flag_upd(flags1_r, ev_f1, wr_lane0 & sel_f1,
                            i_pwdata[7:0], ifr_pkg::WMASK_FLAGS1);
      flags2_nxt = flag_upd(flags2_r, ev_f2, wr_lane0 & sel_f2,
                            i_pwdata[7:0], ifr_pkg::WMASK_FLAGS2) &
                   ifr_pkg::IMPL_FLAGS2;
      flags3_nxt = flag_upd(flags3_r, ev_f3, wr_lane0 & sel_f3,
                            i_pwdata[7:0], ifr_pkg::WMASK_FLAGS3);
      // read-only buffer bits mirror the serial ports
      flags1_nxt[ifr_pkg::BIT_SER1_RX] = i_status.serial1_rx_full;
      flags1_nxt[ifr_pkg::BIT_SER1_TX] = i_status.serial1_tx_empty;
      flags3_nxt[ifr_pkg::BIT_SER2_RX] = i_status.serial2_rx_full;
      flags3_nxt[ifr_pkg::BIT_SER2_TX] = i_status.serial2_tx_empty;
      flags3_nxt = flags3_nxt & ifr_pkg::IMPL_FLAGS3;
      config_nxt = (wr_lane0 & sel_cfg) ?
                   (i_pwdata[7:0] & ifr_pkg::WMASK_CONFIG) : config_r;
   end

   // external control register
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ext_ctrl3_r <= ifr_pkg::RST_EXT_CTRL3;
      end else if (i_clk_en) begin
         ext_ctrl3_r <= ext_ctrl3_nxt;
      end
   end

   // peripheral flag register one
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         flags1_r <= ifr_pkg::RST_FLAGS;
      end else if (i_clk_en) begin
         flags1_r <= flags1_nxt;
      end
   end

   // peripheral flag register two
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         flags2_r <= ifr_pkg::RST_FLAGS;
      end else if (i_clk_en) begin
         flags2_r <= flags2_nxt;
      end
   end

   // peripheral flag register three
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         flags3_r <= ifr_pkg::RST_FLAGS;
      end else if (i_clk_en) begin
         flags3_r <= flags3_nxt;
      end
   end

   // configuration register
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         config_r <= ifr_pkg::RST_CONFIG;
      end else if (i_clk_en) begin
         config_r <= config_nxt;
      end
   end

   // external request gating by enable, routing by priority
   assign prio_en  = config_r[ifr_pkg::BIT_PRIO_EN];
   assign ext_req  = {ext_ctrl3_r[ifr_pkg::BIT_EXT3_FLAG] & ext_ctrl3_r[ifr_pkg::BIT_EXT3_EN],
                      ext_ctrl3_r[ifr_pkg::BIT_EXT2_FLAG] & ext_ctrl3_r[ifr_pkg::BIT_EXT2_EN],
                      ext_ctrl3_r[ifr_pkg::BIT_EXT1_FLAG] & ext_ctrl3_r[ifr_pkg::BIT_EXT1_EN]};
   // priority of each line, line 3 from the configuration register
   assign ext_prio = {config_r[ifr_pkg::BIT_EXT3_PRIO],
                      ext_ctrl3_r[ifr_pkg::BIT_EXT2_PRIO],
                      ext_ctrl3_r[ifr_pkg::BIT_EXT1_PRIO]};

   // without priority levels every line goes to the high request
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         irq_high_r <= 1'b0;
         irq_low_r  <= 1'b0;
      end else if (i_clk_en) begin
         irq_high_r <= prio_en ? |(ext_req & ext_prio) : |ext_req;
         irq_low_r  <= prio_en & |(ext_req & ~ext_prio);
      end
   end

   // outputs straight from flip-flops
   assign o_prdata       = prdata_r;
   assign o_pready       = pready_r;
   assign o_pslverr      = pslverr_r;
   assign o_ext_ctrl3    = ext_ctrl3_r;
   assign o_flags1       = flags1_r;
   assign o_flags2       = flags2_r;
   assign o_flags3       = flags3_r;
   assign o_ext_irq_high = irq_high_r;
   assign o_ext_irq_low  = irq_low_r;

endmodule

// ==== verif/ifr_top_asserts.sv ====
// concurrent checks on the ports of the flag block
`timescale 1ns/1ps
module ifr_top_asserts (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_resetn,
   input  wire logic                   i_clk_en,
   input  wire logic                   i_psel,
   input  wire logic                   i_penable,
   input  wire ifr_pkg::ifr_events_t   i_events,
   input  wire ifr_pkg::ifr_status_t   i_status,
   input  wire ifr_pkg::ifr_ccp_mode_t i_capcomp1_mode,
   input  wire logic [31:0]            o_prdata,
   input  wire logic                   o_pready,
   input  wire logic                   o_pslverr,
   input  wire logic [7:0]             o_ext_ctrl3,
   input  wire logic [7:0]             o_flags1,
   input  wire logic [7:0]             o_flags2,
   input  wire logic [7:0]             o_flags3,
   input  wire logic                   o_ext_irq_high,
   input  wire logic                   o_ext_irq_low
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   // first access cycle, then a single answer cycle
   sequence s_taken;
      i_psel && i_penable && !o_pready && i_clk_en;
   endsequence
   sequence s_answer;
      o_pready ##1 !o_pready;
   endsequence
   apb_answer_a: assert property (s_taken |=> s_answer)
      else $error("bus answer missing or too long");
   err_with_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("error flag outside answer");
   rdata_quiet_a: assert property ((!o_pready || o_pslverr) |-> o_prdata == 32'h0)
      else $error("read data outside answer");
   tmr1_set_a: assert property (i_clk_en && i_events.timer1_overflow |=> o_flags1[0])
      else $error("timer one flag not set");
   conv_set_a: assert property (i_clk_en && i_events.conversion_done |=> o_flags1[6])
      else $error("conversion flag not set");
   osc_set_a: assert property (i_clk_en && i_events.oscillator_fail |=> o_flags2[7])
      else $error("oscillator flag not set");
   cc1_capture_a: assert property (i_clk_en && i_events.capcomp1_capture
      && i_capcomp1_mode == ifr_pkg::CCP_CAPTURE |=> o_flags1[2])
      else $error("capture flag not set");
   unimpl_zero_a: assert property (o_flags2[5:4] == 2'b00 && o_flags3[7:6] == 2'b00
      && o_flags3[3:1] == 3'b000)
      else $error("unimplemented bit set");
   ro_follow_a: assert property ($past(i_clk_en) && $past(i_resetn)
      |-> {o_flags1[5:4], o_flags3[5:4]} == $past(i_status))
      else $error("buffer state bits stale");
   irq_cause_a: assert property (i_clk_en |=> (o_ext_irq_high || o_ext_irq_low)
      == $past(|(o_ext_ctrl3[5:3] & o_ext_ctrl3[2:0])))
      else $error("external request mismatch");
endmodule

// ==== verif/ifr_periph_model.sv ====
// peripheral event and buffer-state source beside the flag block
`timescale 1ns/1ps
module ifr_periph_model (
   input  wire logic [15:0]      i_fire,
   input  wire logic [15:0]      i_on_ready,
   input  wire logic             i_pready,
   input  wire logic [3:0]       i_levels,
   output ifr_pkg::ifr_events_t  o_events,
   output ifr_pkg::ifr_status_t  o_status
);
   // one-cycle pulses, or pulses on the edge a register write lands
   assign o_events = ifr_pkg::ifr_events_t'(i_fire | (i_on_ready & {16{i_pready}}));
   // serial buffer states are plain levels
   assign o_status = ifr_pkg::ifr_status_t'(i_levels);
endmodule

// ==== verif/test_ifr_top.sv ====
// self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module test_ifr_top;
   logic                   clk;
   logic                   rstn;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [7:0]             paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [2:0]             ext_line;
   ifr_pkg::ifr_events_t   events;
   ifr_pkg::ifr_status_t   status;
   ifr_pkg::ifr_ccp_mode_t m1, m2, m3;
   logic [7:0]             ctrl3, f1, f2, f3;
   logic                   irq_hi, irq_lo;
   logic [15:0]            fire, onr;
   logic [3:0]             lev;
   logic                   clk_en;
   int                     error_cnt = 0;
   int                     tests_run = 0;
   int                     cyc = 0;
   ifr_pkg::ifr_ccp_mode_t mtab [3] = '{ifr_pkg::CCP_CAPTURE, ifr_pkg::CCP_COMPARE,
                                        ifr_pkg::CCP_PWM};
   logic [7:0]             rst_tab [5] = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h1e};

   ifr_top i_ifr_top (.i_ref_clk(clk), .i_resetn(rstn), .i_clk_en(clk_en), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_ext_line(ext_line), .i_events(events), .i_status(status), .i_capcomp1_mode(m1),
      .i_capcomp2_mode(m2), .i_capcomp3_mode(m3), .o_ext_ctrl3(ctrl3), .o_flags1(f1),
      .o_flags2(f2), .o_flags3(f3), .o_ext_irq_high(irq_hi), .o_ext_irq_low(irq_lo));
   ifr_periph_model i_ifr_periph_model (.i_fire(fire), .i_on_ready(onr), .i_pready(pready),
      .i_levels(lev), .o_events(events), .o_status(status));

   // clock and hang guard
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   task automatic results();
      $display("errors %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one bus transfer, held until the answer edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, {24'h0, d}, q, e);
   endtask

   // read and compare data together with the error flag
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      tests_run++;
      if ({e, q} !== {xe, 24'h0, x}) begin
         error_cnt++;
         $display("mismatch %0t addr %h got %h/%b", $time, a, q, e);
      end
   endtask

   task automatic chk_irq(input logic xh, input logic xl);
      repeat (2) @(posedge clk);
      tests_run++;
      if ({irq_hi, irq_lo} !== {xh, xl}) begin
         error_cnt++;
         $display("mismatch %0t request outputs %b%b", $time, irq_hi, irq_lo);
      end
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
   endtask

   // flags {three, two, one} that a single event index should leave set
   function automatic logic [23:0] ev_map(input int i);
      logic [23:0] t;
      t = 24'h0;
      case (i)
         15: t[7] = 1'b1;
         14: t[6] = 1'b1;
         13: t[3] = 1'b1;
         12: t[2] = (m1 == ifr_pkg::CCP_CAPTURE);
         11: t[2] = (m1 == ifr_pkg::CCP_COMPARE);
         10: t[1] = 1'b1;
         9: t[0] = 1'b1;
         8: t[15] = 1'b1;
         7: t[14] = 1'b1;
         6: t[11] = 1'b1;
         5: t[10] = 1'b1;
         4: t[9] = 1'b1;
         3: t[8] = (m2 == ifr_pkg::CCP_CAPTURE);
         2: t[8] = (m2 == ifr_pkg::CCP_COMPARE);
         1: t[16] = (m3 == ifr_pkg::CCP_CAPTURE);
         default: t[16] = (m3 == ifr_pkg::CCP_COMPARE);
      endcase
      return t;
   endfunction

   // readback after a write, with buffer-state bits and dead bits
   function automatic logic [7:0] exp_rw(input logic [7:0] a, input logic [7:0] w,
                                         input logic [3:0] s);
      case (a)
         8'h04: return (w & 8'hcf) | {2'b00, s[3:2], 4'h0};
         8'h08: return w & 8'hcf;
         8'h0c: return (w & 8'h01) | {2'b00, s[1:0], 4'h0};
         default: return w;
      endcase
   endfunction

   initial begin
      logic [23:0] t;
      logic [7:0]  d;
      logic [7:0]  a;
      logic [3:0]  s;
      {rstn, psel, penable, pwrite, paddr, pwdata, ext_line} = '0;
      {fire, onr, lev} = '0;
      clk_en = 1'b1;
      m1 = ifr_pkg::CCP_CAPTURE;
      m2 = ifr_pkg::CCP_CAPTURE;
      m3 = ifr_pkg::CCP_CAPTURE;
      void'($urandom(97));
      do_reset();
      // reset values and an unmapped place
      for (int k = 0; k < 5; k++) chk_reg(8'(4 * k), rst_tab[k], 1'b0);
      chk_reg(8'h14, 8'h00, 1'b1);
      // every event in every capture/compare mode
      for (int i = 0; i < 48; i++) begin
         m1 <= mtab[i / 16];
         m2 <= mtab[i / 16];
         m3 <= mtab[i / 16];
         wr(ifr_pkg::OFS_FLAGS1, 8'h00);
         wr(ifr_pkg::OFS_FLAGS2, 8'h00);
         wr(ifr_pkg::OFS_FLAGS3, 8'h00);
         fire <= 16'h1 << (i % 16);
         @(posedge clk);
         fire <= 16'h0;
         @(posedge clk);
         t = ev_map(i % 16);
         chk_reg(ifr_pkg::OFS_FLAGS1, t[7:0], 1'b0);
         chk_reg(ifr_pkg::OFS_FLAGS2, t[15:8], 1'b0);
         chk_reg(ifr_pkg::OFS_FLAGS3, t[23:16], 1'b0);
      end
      // an event on the edge of a clearing write
      onr <= 16'h0200;
      wr(ifr_pkg::OFS_FLAGS1, 8'h00);
      onr <= 16'h0;
      chk_reg(ifr_pkg::OFS_FLAGS1, 8'h01, 1'b0);
      // a frozen block misses an event pulse and keeps its flags
      clk_en <= 1'b0;
      fire <= 16'h4000;
      @(posedge clk);
      clk_en <= 1'b1;
      fire <= 16'h0;
      chk_reg(ifr_pkg::OFS_FLAGS1, 8'h01, 1'b0);
      // random writes with random buffer states
      for (int k = 0; k < 24; k++) begin
         d = 8'($urandom);
         s = 4'($urandom);
         a = 8'(4 * (k % 4));
         lev <= s;
         wr(a, d);
         chk_reg(a, exp_rw(a, d, s), 1'b0);
      end
      lev <= 4'h0;
      do_reset();
      // line edges latch with all enables off
      for (int k = 0; k < 3; k++) begin
         ext_line[k] <= 1'b1;
         repeat (4) @(posedge clk);
         chk_reg(ifr_pkg::OFS_EXT_CTRL3, 8'hc0 | ((8'h1 << (k + 1)) - 8'h1), 1'b0);
      end
      chk_irq(1'b0, 1'b0);
      wr(ifr_pkg::OFS_EXT_CTRL3, 8'hc0);
      wr(ifr_pkg::OFS_EXT_CTRL3, 8'hd0);
      ext_line[1] <= 1'b0;
      repeat (3) @(posedge clk);
      ext_line[1] <= 1'b1;
      repeat (4) @(posedge clk);
      chk_irq(1'b1, 1'b0);
      wr(ifr_pkg::OFS_EXT_CTRL3, 8'h52);
      chk_irq(1'b1, 1'b0);
      wr(ifr_pkg::OFS_CONFIG, 8'h1f);
      chk_irq(1'b0, 1'b1);
      wr(ifr_pkg::OFS_EXT_CTRL3, 8'hd2);
      chk_irq(1'b1, 1'b0);
      wr(ifr_pkg::OFS_EXT_CTRL3, 8'hc2);
      chk_irq(1'b0, 1'b0);
      // lines already high at reset release are no edge
      do_reset();
      repeat (4) @(posedge clk);
      chk_reg(ifr_pkg::OFS_EXT_CTRL3, 8'hc0, 1'b0);
      results();
   end
endmodule

bind ifr_top ifr_top_asserts i_ifr_top_asserts (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
   .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable), .i_events(i_events),
   .i_status(i_status), .i_capcomp1_mode(i_capcomp1_mode), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_ext_ctrl3(o_ext_ctrl3),
   .o_flags1(o_flags1), .o_flags2(o_flags2), .o_flags3(o_flags3),
   .o_ext_irq_high(o_ext_irq_high), .o_ext_irq_low(o_ext_irq_low));
